// file: rtl/sqs_pkg.sv
// Constants and types for the packed shift and Q15 subtract unit
package sqs_pkg;
    // ------------------------------------------------------------
    // Instruction field positions
    // ------------------------------------------------------------
    localparam int MAJOR_HI = 31;
    localparam int MAJOR_LO = 26;
    localparam int FIELD_ONE_HI = 25;
    localparam int FIELD_ONE_LO = 21;
    localparam int FIELD_TWO_HI = 20;
    localparam int FIELD_TWO_LO = 16;
    localparam int DEST_HI = 15;
    localparam int DEST_LO = 11;
    localparam int IMM_SA_HI = 15;
    localparam int IMM_SA_LO = 13;
    localparam int SUB_OP_HI = 12;
    localparam int SUB_OP_LO = 6;
    localparam int MINOR_HI = 5;
    localparam int MINOR_LO = 0;
    localparam int FUNC10_HI = 9;
    localparam int FUNC11_HI = 10;
    localparam int ZERO_BIT = 10;
    // ------------------------------------------------------------
    // Opcode values
    // ------------------------------------------------------------
    localparam logic [5:0] MAJOR_OPCODE_GROUP_A = 6'h00;
    localparam logic [5:0] MINOR_OPCODE_GROUP_EXT = 6'h3C;
    localparam logic [6:0] SUB_BYTE_IMM = 7'h61;
    localparam logic [9:0] FUNC_HALF_VAR = 10'h315;
    localparam logic [9:0] FUNC_BYTE_VAR = 10'h355;
    localparam logic [10:0] FUNC_SUB_WRAP = 11'h20D;
    localparam logic [10:0] FUNC_SUB_SAT = 11'h60D;
    // ------------------------------------------------------------
    // Q15 limits and control register flag
    // ------------------------------------------------------------
    localparam logic [15:0] Q15_MAX = 16'h7FFF;
    localparam logic [15:0] Q15_MIN = 16'h8000;
    localparam int OUFLAG_BIT = 20;
    // ------------------------------------------------------------
    // Operation selector
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SQS_OP_NONE = 3'b000,
        SQS_OP_BYTE_IMM = 3'b001,
        SQS_OP_HALF_VAR = 3'b010,
        SQS_OP_BYTE_VAR = 3'b011,
        SQS_OP_SUB_WRAP = 3'b100,
        SQS_OP_SUB_SAT = 3'b101
    } sqs_op_t;
endpackage : sqs_pkg

// file: rtl/sqs_unit.sv
// Packed logical right shifts and Q15 halfword pair subtraction
//
// Behaviour
// - Immediate byte shift decoded: major 000000, minor 111100, sub 1100001, amount 15..13.
// - Halfword variable shift uses low four bits of shift operand; rest ignored.
// - Halfword variable shift: bits 9..0 1100010101, bit 10 zero.
// - Byte variable shift uses low three bits of shift operand, zero fill.
// - Byte variable shift: bits 9..0 1101010101, bit 10 zero.
// - No operand-dependent exception from any of these operations.
// - Reserved or DSP-disabled condition raises its exception instead of executing.
// - Subtract each halfword of source two from source one, signed Q15.
// - Wrapping variant writes low 16 bits of overflowed difference.
// - Saturating variant clamps overflow to 7FFF, underflow to 8000.
// - Any lane overflow in either variant requests setting control bit 20.
`timescale 1ns/10ps
module sqs_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Decoded instruction and operands
    input wire logic issue,
    input wire logic [31:0] instr,
    input wire logic [31:0] operand_one,
    input wire logic [31:0] operand_two,
    input wire logic dsp_enabled,
    // Result and status
    output logic result_valid,
    output logic [31:0] result,
    output logic [4:0] dest_reg,
    output logic ouflag_set,
    output logic [31:0] ouflag_set_mask,
    output logic exc_reserved,
    output logic exc_dsp_disabled
);
    import sqs_pkg::*;

    // ------------------------------------------------------------
    // Lane helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] shift_byte(input logic [7:0] a, input logic [2:0] s);
        shift_byte = a >> s;
    endfunction : shift_byte

    function automatic logic [16:0] sub_wide(input logic [15:0] a, input logic [15:0] b);
        sub_wide = {a[15], a} - {b[15], b};
    endfunction : sub_wide

    function automatic logic [15:0] clamp_q15(input logic [16:0] d, input logic sat);
        if (sat && (d[16] != d[15])) begin
            clamp_q15 = d[16] ? Q15_MIN : Q15_MAX;
        end else begin
            clamp_q15 = d[15:0];
        end
    endfunction : clamp_q15

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_sync;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic major_ok = instr[MAJOR_HI:MAJOR_LO] == MAJOR_OPCODE_GROUP_A;
    wire logic is_byte_imm = major_ok
        && instr[MINOR_HI:MINOR_LO] == MINOR_OPCODE_GROUP_EXT
        && instr[SUB_OP_HI:SUB_OP_LO] == SUB_BYTE_IMM;
    wire logic is_half_var = major_ok && !instr[ZERO_BIT]
        && instr[FUNC10_HI:0] == FUNC_HALF_VAR;
    wire logic is_byte_var = major_ok && !instr[ZERO_BIT]
        && instr[FUNC10_HI:0] == FUNC_BYTE_VAR;
    wire logic is_sub_wrap = major_ok && instr[FUNC11_HI:0] == FUNC_SUB_WRAP;
    wire logic is_sub_sat = major_ok && instr[FUNC11_HI:0] == FUNC_SUB_SAT;

    sqs_op_t op;
    assign op = is_byte_imm ? SQS_OP_BYTE_IMM :
                is_half_var ? SQS_OP_HALF_VAR :
                is_byte_var ? SQS_OP_BYTE_VAR :
                is_sub_wrap ? SQS_OP_SUB_WRAP :
                is_sub_sat ? SQS_OP_SUB_SAT : SQS_OP_NONE;

    wire logic [4:0] fld_one = instr[FIELD_ONE_HI:FIELD_ONE_LO];
    wire logic [4:0] fld_two = instr[FIELD_TWO_HI:FIELD_TWO_LO];
    wire logic [4:0] fld_dest = instr[DEST_HI:DEST_LO];
    wire logic [2:0] imm_sa = instr[IMM_SA_HI:IMM_SA_LO];

    // Reserved or disabled stops execution; operand values never do
    wire logic known_op = op != SQS_OP_NONE;
    wire logic next_exc_reserved = issue && !known_op;
    wire logic next_exc_dsp = issue && known_op && !dsp_enabled;
    wire logic exec = issue && known_op && dsp_enabled;

    // ------------------------------------------------------------
    // Shift datapath
    // ------------------------------------------------------------
    // Immediate: source is operand_one, byte variable: value is operand_one
    wire logic [3:0] half_sa = operand_two[3:0];
    wire logic [2:0] byte_var_sa = operand_two[2:0];
    wire logic [2:0] byte_sa = (op == SQS_OP_BYTE_IMM) ? imm_sa : byte_var_sa;
    wire logic [31:0] byte_res = {shift_byte(operand_one[31:24], byte_sa),
                                  shift_byte(operand_one[23:16], byte_sa),
                                  shift_byte(operand_one[15:8], byte_sa),
                                  shift_byte(operand_one[7:0], byte_sa)};
    wire logic [31:0] half_res = {operand_one[31:16] >> half_sa,
                                  operand_one[15:0] >> half_sa};

    // ------------------------------------------------------------
    // Q15 subtract datapath
    // ------------------------------------------------------------
    wire logic [16:0] diff_hi = sub_wide(operand_one[31:16], operand_two[31:16]);
    wire logic [16:0] diff_lo = sub_wide(operand_one[15:0], operand_two[15:0]);
    wire logic sat_mode = op == SQS_OP_SUB_SAT;
    wire logic [31:0] sub_res = {clamp_q15(diff_hi, sat_mode),
                                 clamp_q15(diff_lo, sat_mode)};
    wire logic lane_ov = (diff_hi[16] != diff_hi[15])
                      || (diff_lo[16] != diff_lo[15]);
    wire logic is_sub = (op == SQS_OP_SUB_WRAP) || sat_mode;
    wire logic next_ouflag = exec && is_sub && lane_ov;

    wire logic [31:0] next_result =
        (op == SQS_OP_HALF_VAR) ? half_res :
        is_sub ? sub_res :
        byte_res;
    wire logic [4:0] next_dest = (op == SQS_OP_BYTE_IMM) ? fld_one : fld_dest;
    wire logic [31:0] flag_mask = 32'h0000_0001 << OUFLAG_BIT;

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    // Datapath is combinational; flopped once for flop-driven outputs
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            result_valid <= 1'b0;
            result <= 32'h0000_0000;
            dest_reg <= 5'h00;
            ouflag_set <= 1'b0;
            ouflag_set_mask <= 32'h0000_0000;
            exc_reserved <= 1'b0;
            exc_dsp_disabled <= 1'b0;
        end else if (clk_en) begin
            result_valid <= exec;
            result <= exec ? next_result : 32'h0000_0000;
            dest_reg <= exec ? next_dest : 5'h00;
            ouflag_set <= next_ouflag;
            ouflag_set_mask <= next_ouflag ? flag_mask : 32'h0000_0000;
            exc_reserved <= next_exc_reserved;
            exc_dsp_disabled <= next_exc_dsp;
        end
    end

    // Source field two only names the operand_two register
    wire logic unused_fields = ^{fld_two};
endmodule : sqs_unit

// file: bench/sqs_pipe_model.sv
// Pipeline side model holding the sticky overflow bit of dsp_control_reg
`timescale 1ns/10ps
module sqs_pipe_model (
    // Clock, reset and flag request
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ouflag_set,
    input wire logic [31:0] ouflag_set_mask,
    // Control register copy
    output logic [31:0] dsp_control_reg
);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) dsp_control_reg <= 32'h0;
        else if (ouflag_set) dsp_control_reg <= dsp_control_reg | ouflag_set_mask;
    end
endmodule : sqs_pipe_model

// file: bench/sqs_unit_properties.sv
// Port level checks of the packed shift and Q15 subtract unit
`timescale 1ns/10ps
module sqs_unit_checker (
    // Clock, reset and inputs
    input wire logic clk, input wire logic reset_n, input wire logic clk_en,
    input wire logic issue, input wire logic [31:0] instr, input wire logic dsp_enabled,
    input wire logic [31:0] operand_one, input wire logic [31:0] operand_two,
    // Outputs
    input wire logic result_valid, input wire logic [31:0] result, input wire logic [4:0] dest_reg,
    input wire logic ouflag_set, input wire logic [31:0] ouflag_set_mask,
    input wire logic exc_reserved, input wire logic exc_dsp_disabled
);
    import sqs_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_excl; $onehot0({result_valid, exc_reserved, exc_dsp_disabled}); endproperty
    a_excl: assert property (p_excl) else $error("outcomes overlap");
    property p_answer; issue && clk_en |=> result_valid || exc_reserved || exc_dsp_disabled;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_idle; clk_en && !issue |=> !result_valid; endproperty
    a_idle: assert property (p_idle) else $error("result without issue");
    property p_off; issue && clk_en && !dsp_enabled |=> !result_valid; endproperty
    a_off: assert property (p_off) else $error("ran while disabled");
    property p_mask; ouflag_set_mask == (ouflag_set ? 32'h0010_0000 : 32'h0); endproperty
    a_mask: assert property (p_mask) else $error("bad flag mask");
    property p_flag; ouflag_set |-> result_valid; endproperty
    a_flag: assert property (p_flag) else $error("flag without result");
    property p_zero; !result_valid |-> result == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("stray result");
    property p_half; issue && clk_en && dsp_enabled && instr[31:26] == 6'h00
        && instr[10:0] == {1'b0, FUNC_HALF_VAR} |=> result == {($past(operand_one[31:16])
        >> $past(operand_two[3:0])), ($past(operand_one[15:0]) >> $past(operand_two[3:0]))};
    endproperty
    a_half: assert property (p_half) else $error("bad halfword shift");
    property p_dest; issue && clk_en && dsp_enabled && instr[31:26] == 6'h00
        && instr[5:0] == 6'h3C && instr[12:6] == 7'h61 |=> dest_reg == $past(instr[25:21]);
    endproperty
    a_dest: assert property (p_dest) else $error("bad immediate shift destination");
    c_flag: cover property (ouflag_set);
    c_res: cover property (exc_reserved);
    c_off: cover property (exc_dsp_disabled);
endmodule : sqs_unit_checker
bind sqs_unit sqs_unit_checker chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .issue(issue),
    .instr(instr), .dsp_enabled(dsp_enabled), .operand_one(operand_one),
    .operand_two(operand_two), .result_valid(result_valid), .result(result),
    .dest_reg(dest_reg), .ouflag_set(ouflag_set), .ouflag_set_mask(ouflag_set_mask),
    .exc_reserved(exc_reserved), .exc_dsp_disabled(exc_dsp_disabled));

// file: bench/test_simd_shift_right_and_q15_subtract.sv
// Directed bench for the packed shift and Q15 subtract unit
`timescale 1ns/10ps
module test_simd_shift_right_and_q15_subtract;
    import sqs_pkg::*;
    logic clk = 0, reset_n = 0, clk_en = 1, issue = 0, dsp_enabled = 1;
    logic result_valid, ouflag_set, exc_reserved, exc_dsp_disabled;
    logic [4:0] dest_reg;
    logic [31:0] instr = 0, operand_one = 0, operand_two = 0;
    logic [31:0] result, ouflag_set_mask, dsp_control_reg;
    int failures = 0, checked = 0, cycles = 0;
    sqs_unit dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .issue(issue), .instr(instr),
        .operand_one(operand_one), .operand_two(operand_two), .dsp_enabled(dsp_enabled),
        .result_valid(result_valid), .result(result), .dest_reg(dest_reg),
        .ouflag_set(ouflag_set), .ouflag_set_mask(ouflag_set_mask),
        .exc_reserved(exc_reserved), .exc_dsp_disabled(exc_dsp_disabled));
    sqs_pipe_model pipe (.clk(clk), .reset_n(reset_n), .ouflag_set(ouflag_set),
        .ouflag_set_mask(ouflag_set_mask), .dsp_control_reg(dsp_control_reg));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end
    function logic [31:0] bx(logic [31:0] v, int n);
        return {v[31:24] >> n, v[23:16] >> n, v[15:8] >> n, v[7:0] >> n};
    endfunction : bx
    task compare(string what, logic [31:0] seen, logic [31:0] want);
        checked++;
        if (seen !== want) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : compare
    task conclude;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task run(logic [31:0] i, logic [31:0] a, logic [31:0] b);
        @(negedge clk);
        instr = i;
        operand_one = a;
        operand_two = b;
        issue = 1;
        @(negedge clk);
        issue = 0;
    endtask : run
    task t_byte_imm;
        for (int s = 0; s < 8; s++) begin
            run({16'h0067, s[2:0], SUB_BYTE_IMM, MINOR_OPCODE_GROUP_EXT}, 32'hF0817F01, 32'hF0817F01);
            compare("imm", result, bx(32'hF0817F01, s));
            compare("imm dest", {27'h0, dest_reg}, 32'h3);
        end
    endtask : t_byte_imm
    task t_var;
        for (int s = 0; s < 16; s++) begin
            run({16'h0022, 5'h09, 1'b0, FUNC_HALF_VAR}, 32'h8001FFFF, 32'hFFFFFFF0 | s);
            compare("half", result, {16'h8001 >> s, 16'hFFFF >> s});
            compare("half dest", {27'h0, dest_reg}, 32'h9);
            run({16'h0022, 5'h09, 1'b0, FUNC_BYTE_VAR}, 32'hF0817F01, 32'hFFFFFFF8 | s);
            compare("byte", result, bx(32'hF0817F01, s % 8));
        end
    endtask : t_var
    task t_sub;
        compare("flag idle", dsp_control_reg, 32'h0);
        for (int k = 0; k < 2; k++) begin
            run({16'h0022, 5'h04, k ? FUNC_SUB_SAT : FUNC_SUB_WRAP}, 32'h80007FFF, 32'h0001FFFF);
            compare("sub edge", result, k ? 32'h80007FFF : 32'h7FFF8000);
            compare("flag", {31'h0, ouflag_set}, 32'h1);
            run({16'h0022, 5'h04, k ? FUNC_SUB_SAT : FUNC_SUB_WRAP}, 32'h12340005, 32'h02340007);
            compare("sub", result, 32'h1000FFFE);
            compare("no flag", {31'h0, ouflag_set}, 32'h0);
        end
        compare("sticky", dsp_control_reg, 32'h0010_0000);
    endtask : t_sub
    task t_refuse;
        run(32'hFC000000, 32'h1, 32'h1);
        compare("reserved", {30'h0, exc_reserved, result_valid}, 32'h2);
        dsp_enabled = 0;
        run({16'h0022, 5'h09, 1'b0, FUNC_HALF_VAR}, 32'h1, 32'h1);
        compare("disabled", {30'h0, exc_dsp_disabled, result_valid}, 32'h2);
        dsp_enabled = 1;
        clk_en = 0;
        run(32'hFC000000, 32'h1, 32'h1);
        compare("frozen", {30'h0, exc_dsp_disabled, exc_reserved}, 32'h2);
        clk_en = 1;
    endtask : t_refuse
    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1;
        repeat (3) @(negedge clk);
        t_byte_imm();
        t_var();
        t_sub();
        t_refuse();
        conclude();
    end
endmodule : test_simd_shift_right_and_q15_subtract
